//--- verilog/cfs_pkg.sv
// Shared constants and carrier types for the core flag register block
package cfs_pkg;

  // ----------------------------------------------------------------
  // Bus register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_FLAGS  = 8'h00; // Processor flag word
  localparam logic [7:0] OFF_STATUS = 8'h04; // Sticky event bits, W1C
  localparam logic [7:0] OFF_MASK   = 8'h08; // Event enable mask

  // ----------------------------------------------------------------
  // Flag word layout
  // ----------------------------------------------------------------
  localparam int FLAG_W     = 11; // Implemented flag bits
  localparam int POS_BANK   = 0;  // Register bank selector
  localparam int POS_OVF    = 1;  // Integer overflow
  localparam int POS_IEN    = 2;  // Maskable interrupt enable
  localparam int POS_STK    = 3;  // Stack pointer selector
  localparam int POS_FUF    = 4;  // Float underflow
  localparam int POS_FOF    = 5;  // Float overflow
  localparam int POS_PRI_LO = 8;  // Priority level, low bit
  localparam int PRI_W      = 3;  // Priority level width
  localparam logic [FLAG_W-1:0] FLAGS_RST = 11'h000; // Reset value

  // Level 7 shuts out every maskable request
  localparam logic [PRI_W-1:0] PRI_ALL_OFF = 3'h7;
  // Highest software number that forces the interrupt stack
  localparam logic [7:0] SWI_STK_MAX = 8'h7f;

  // ----------------------------------------------------------------
  // Event status layout
  // ----------------------------------------------------------------
  localparam int EV_W      = 5; // Event bits
  localparam int EV_OVF    = 0; // Integer overflow seen
  localparam int EV_FUF    = 1; // Float underflow seen
  localparam int EV_FOF    = 2; // Float overflow seen
  localparam int EV_ACCEPT = 3; // Interrupt accepted
  localparam int EV_SWI    = 4; // Software interrupt executed
  localparam logic [EV_W-1:0] EV_RST = 5'h00; // Reset value

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0; // Mapped access
  localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped access

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;    // Integer result retires this cycle
    logic       overflow; // Result overflowed
  } cfs_int_op_t;

  typedef struct packed {
    logic       valid;     // Float result retires this cycle
    logic       underflow; // Result underflowed
    logic       overflow;  // Result overflowed
    logic       subnormal; // Some operand was subnormal
  } cfs_fp_op_t;

  typedef struct packed {
    logic             valid;    // Request pending
    logic             maskable; // Obeys enable flag and level
    logic [PRI_W-1:0] level;    // Request level
  } cfs_irq_req_t;

  typedef struct packed {
    logic       valid;  // Software interrupt executes
    logic [7:0] number; // Software interrupt number
  } cfs_swi_t;

  typedef struct packed {
    logic              valid; // Instruction writes flag word
    logic [FLAG_W-1:0] data;  // New flag word
  } cfs_flag_wr_t;

endpackage

//--- verilog/cfs_int_gate.sv
// Interrupt acceptance gate: enable flag and priority level check
`timescale 1ns/1ps
module cfs_int_gate
(
  input  wire cfs_pkg::cfs_irq_req_t    req,    // Incoming request
  input  wire logic                     ien,    // Enable flag
  input  wire logic [cfs_pkg::PRI_W-1:0] pri,   // Current level
  output logic                          accept  // Accept pulse
);

  // ----------------------------------------------------------------
  // Acceptance decision
  // ----------------------------------------------------------------
  // Level must be strictly higher; at level 7 nothing can exceed it,
  // so the explicit check only documents intent
  always_comb
  begin
    if (!req.valid)
      accept = 1'b0;
    else if (!req.maskable)
      accept = 1'b1;                         // Non-maskable passes
    else
      accept = ien
             && (req.level > pri)
             && (pri != cfs_pkg::PRI_ALL_OFF);
  end

endmodule

//--- verilog/cfs_irq_ctrl.sv
// Sticky event status, mask and level interrupt output
`timescale 1ns/1ps
module cfs_irq_ctrl
(
  input  wire logic                     aclk,     // Core clock
  input  wire logic                     aresetn,  // Sync reset, low
  input  wire logic [cfs_pkg::EV_W-1:0] events,   // Event pulses
  input  wire logic                     clr_en,   // Status write
  input  wire logic [cfs_pkg::EV_W-1:0] clr_bits, // Ones to clear
  input  wire logic                     mask_en,  // Mask write
  input  wire logic [cfs_pkg::EV_W-1:0] mask_val, // New mask
  output logic      [cfs_pkg::EV_W-1:0] status,   // Sticky bits
  output logic      [cfs_pkg::EV_W-1:0] mask,     // Mask bits
  output logic                          irq       // Level interrupt
);

  typedef struct packed {
    logic [cfs_pkg::EV_W-1:0] status; // Sticky bits
    logic [cfs_pkg::EV_W-1:0] mask;   // Enables
    logic                     irq;    // Registered output
  } cfs_irq_state_t;

  cfs_irq_state_t st_reg;  // Current state
  cfs_irq_state_t st_next; // Next state

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Set beats clear so an event in the clearing cycle survives
  always_comb
  begin
    st_next = st_reg;
    if (clr_en)
      st_next.status = st_reg.status & ~clr_bits;
    st_next.status = st_next.status | events;
    if (mask_en)
      st_next.mask = mask_val;
    st_next.irq = |(st_next.status & st_next.mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_reg <= '{status: cfs_pkg::EV_RST, mask: cfs_pkg::EV_RST,
                  irq: 1'b0};
    else
      st_reg <= st_next;
  end

  assign status = st_reg.status;
  assign mask   = st_reg.mask;
  assign irq    = st_reg.irq;

endmodule

//--- verilog/cfs_flags.sv
// Processor flag register with core update ports and bus slave
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module cfs_flags
(
  input  wire logic                 aclk,          // Core clock
  input  wire logic                 aresetn,       // Sync reset, low
  // Core side
  input  wire cfs_pkg::cfs_flag_wr_t flag_wr,      // Instruction write
  input  wire cfs_pkg::cfs_int_op_t  int_op,       // Integer result
  input  wire cfs_pkg::cfs_fp_op_t   fp_op,        // Float result
  input  wire cfs_pkg::cfs_irq_req_t irq_req,      // Interrupt request
  input  wire cfs_pkg::cfs_swi_t     swi,          // Software interrupt
  output logic                      irq_accept,    // Accept pulse
  output logic [cfs_pkg::FLAG_W-1:0] flags,        // Flag word
  output logic                      bank_sel,      // Active bank
  output logic                      stack_sel,     // 1: user pointer
  output logic                      irq,           // Event interrupt
  // AXI4-Lite slave
  input  wire logic [7:0]           s_axi_awaddr,  // Write address
  input  wire logic                 s_axi_awvalid, // Write addr valid
  output logic                      s_axi_awready, // Write addr ready
  input  wire logic [31:0]          s_axi_wdata,   // Write data
  input  wire logic [3:0]           s_axi_wstrb,   // Byte enables
  input  wire logic                 s_axi_wvalid,  // Write data valid
  output logic                      s_axi_wready,  // Write data ready
  output logic [1:0]                s_axi_bresp,   // Write response
  output logic                      s_axi_bvalid,  // Response valid
  input  wire logic                 s_axi_bready,  // Response ready
  input  wire logic [7:0]           s_axi_araddr,  // Read address
  input  wire logic                 s_axi_arvalid, // Read addr valid
  output logic                      s_axi_arready, // Read addr ready
  output logic [31:0]               s_axi_rdata,   // Read data
  output logic [1:0]                s_axi_rresp,   // Read response
  output logic                      s_axi_rvalid,  // Read valid
  input  wire logic                 s_axi_rready   // Read ready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [cfs_pkg::FLAG_W-1:0] flags;   // Flag word
    logic                       aw_seen; // Address captured
    logic [7:0]                 aw_addr; // Captured address
    logic                       w_seen;  // Data captured
    logic [31:0]                w_data;  // Captured data
    logic [3:0]                 w_strb;  // Captured strobes
    logic                       bvalid;  // Write response pending
    logic [1:0]                 bresp;   // Write response code
    logic                       rvalid;  // Read data pending
    logic [1:0]                 rresp;   // Read response code
    logic [31:0]                rdata;   // Read data
  } cfs_state_t;

  cfs_state_t st_reg;  // Current state
  cfs_state_t st_next; // Next state

  // Interrupt controller links
  logic [cfs_pkg::EV_W-1:0] ev_pulse;    // Event pulses
  logic [cfs_pkg::EV_W-1:0] ev_status;   // Sticky bits
  logic [cfs_pkg::EV_W-1:0] ev_mask;     // Mask bits
  logic                     stat_wr;     // Status W1C strobe
  logic                     mask_wr;     // Mask write strobe
  logic [cfs_pkg::EV_W-1:0] ev_wdata;    // Written event bits
  logic                     accept;      // Gate decision
  logic                     swi_low;     // Software number <= 127
  logic                     do_write;    // Bus write commits

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge for narrow writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    return res;
  endfunction

  // Mapped offset check, used by the write response path
  function automatic logic is_mapped(input logic [7:0] addr);
    return (addr == cfs_pkg::OFF_FLAGS) ||
           (addr == cfs_pkg::OFF_STATUS) ||
           (addr == cfs_pkg::OFF_MASK);
  endfunction

  // ----------------------------------------------------------------
  // Interrupt acceptance
  // ----------------------------------------------------------------
  cfs_int_gate u_gate
  (
    .req    (irq_req),
    .ien    (st_reg.flags[cfs_pkg::POS_IEN]),
    .pri    (st_reg.flags[cfs_pkg::POS_PRI_LO +: cfs_pkg::PRI_W]),
    .accept (accept)
  );

  assign swi_low  = swi.valid && (swi.number <= cfs_pkg::SWI_STK_MAX);
  assign do_write = st_reg.aw_seen && st_reg.w_seen && !st_reg.bvalid;

  // ----------------------------------------------------------------
  // Event status block
  // ----------------------------------------------------------------
  always_comb
  begin
    ev_pulse = cfs_pkg::EV_RST;
    ev_pulse[cfs_pkg::EV_OVF]    = int_op.valid && int_op.overflow;
    ev_pulse[cfs_pkg::EV_FUF]    = fp_op.valid &&
                                   (fp_op.underflow || fp_op.subnormal);
    ev_pulse[cfs_pkg::EV_FOF]    = fp_op.valid &&
                                   (fp_op.overflow || fp_op.subnormal);
    ev_pulse[cfs_pkg::EV_ACCEPT] = accept;
    ev_pulse[cfs_pkg::EV_SWI]    = swi.valid;
  end

  assign stat_wr  = do_write && (st_reg.aw_addr == cfs_pkg::OFF_STATUS)
                    && st_reg.w_strb[0];
  assign mask_wr  = do_write && (st_reg.aw_addr == cfs_pkg::OFF_MASK)
                    && st_reg.w_strb[0];
  assign ev_wdata = st_reg.w_data[cfs_pkg::EV_W-1:0];

  cfs_irq_ctrl u_irq
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .events   (ev_pulse),
    .clr_en   (stat_wr),
    .clr_bits (ev_wdata),
    .mask_en  (mask_wr),
    .mask_val (ev_wdata),
    .status   (ev_status),
    .mask     (ev_mask),
    .irq      (irq)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Order of precedence on the flag word: bus write, then
  // instruction write, then hardware updates, which always win
  always_comb
  begin
    logic [31:0] merged; // Flag word after byte merge
    merged  = 32'h0000_0000;
    st_next = st_reg;

    // Write address channel
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_next.aw_seen = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end

    // Write data channel, may come before or after address
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_next.w_seen = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end

    // Commit once both halves are held
    if (do_write)
    begin
      st_next.aw_seen = 1'b0;
      st_next.w_seen  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = is_mapped(st_reg.aw_addr) ? cfs_pkg::RESP_OKAY
                                                  : cfs_pkg::RESP_SLVERR;
      if (st_reg.aw_addr == cfs_pkg::OFF_FLAGS)
      begin
        merged = merge_bytes({21'h000000, st_reg.flags},
                             st_reg.w_data, st_reg.w_strb);
        st_next.flags = merged[cfs_pkg::FLAG_W-1:0];
      end
    end

    // Write response retires
    if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;

    // Instruction write to the flag word
    if (flag_wr.valid)
      st_next.flags = flag_wr.data;

    // Integer result updates overflow both ways
    if (int_op.valid)
      st_next.flags[cfs_pkg::POS_OVF] = int_op.overflow;

    // Float result; subnormal input raises both flags
    if (fp_op.valid)
    begin
      st_next.flags[cfs_pkg::POS_FUF] = fp_op.underflow
                                        || fp_op.subnormal;
      st_next.flags[cfs_pkg::POS_FOF] = fp_op.overflow
                                        || fp_op.subnormal;
    end

    // Accepted interrupt shuts further maskable ones out
    if (accept)
      st_next.flags[cfs_pkg::POS_IEN] = 1'b0;

    // Hardware interrupt or low software number: interrupt stack
    if (accept || swi_low)
      st_next.flags[cfs_pkg::POS_STK] = 1'b0;

    // Read channel; one read at a time
    if (s_axi_arvalid && s_axi_arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = 32'h0000_0000;
      st_next.rresp  = cfs_pkg::RESP_OKAY;
      case (s_axi_araddr)
        cfs_pkg::OFF_FLAGS:
          st_next.rdata[cfs_pkg::FLAG_W-1:0] = st_reg.flags;
        cfs_pkg::OFF_STATUS:
          st_next.rdata[cfs_pkg::EV_W-1:0] = ev_status;
        cfs_pkg::OFF_MASK:
          st_next.rdata[cfs_pkg::EV_W-1:0] = ev_mask;
        default:
          st_next.rresp = cfs_pkg::RESP_SLVERR; // Unmapped, data zero
      endcase
    end
    else if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg        <= '0;
      st_reg.flags  <= cfs_pkg::FLAGS_RST;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Ready only while nothing of the same kind is held, which keeps
  // a second write from overtaking an unanswered one
  assign s_axi_awready = !st_reg.aw_seen && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_seen && !st_reg.bvalid;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;

  assign irq_accept = accept;
  assign flags      = st_reg.flags;
  assign bank_sel   = st_reg.flags[cfs_pkg::POS_BANK];
  assign stack_sel  = st_reg.flags[cfs_pkg::POS_STK];

endmodule

//--- bench/cfs_flags_checker.sv
// Concurrent assertion checker for the core flag register block
`timescale 1ns/1ps
module cfs_flags_checker
(
  input wire logic                       aclk,          // Core clock
  input wire logic                       aresetn,       // Sync reset, low
  input wire cfs_pkg::cfs_flag_wr_t      flag_wr,       // Word write
  input wire cfs_pkg::cfs_int_op_t       int_op,        // Integer result
  input wire cfs_pkg::cfs_fp_op_t        fp_op,         // Float result
  input wire cfs_pkg::cfs_irq_req_t      irq_req,       // Request
  input wire cfs_pkg::cfs_swi_t          swi,           // Software int
  input wire logic                       irq_accept,    // Accept pulse
  input wire logic [cfs_pkg::FLAG_W-1:0] flags,         // Flag word
  input wire logic                       bank_sel,      // Active bank
  input wire logic                       stack_sel,     // Stack select
  input wire logic                       s_axi_arvalid, // Read addr valid
  input wire logic                       s_axi_arready, // Read addr ready
  input wire logic                       s_axi_rvalid,  // Read valid
  input wire logic                       s_axi_rready,  // Read ready
  input wire logic [31:0]                s_axi_rdata,   // Read data
  input wire logic                       s_axi_bvalid,  // Resp valid
  input wire logic                       s_axi_bready,  // Resp ready
  input wire logic [1:0]                 s_axi_bresp    // Write response
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] pri;     // Current priority level
  logic       gate_ok; // Maskable request may pass
  assign pri = flags[cfs_pkg::POS_PRI_LO +: cfs_pkg::PRI_W];
  assign gate_ok = flags[cfs_pkg::POS_IEN] && irq_req.level > pri &&
                   pri != cfs_pkg::PRI_ALL_OFF;
  logic       quiet;   // No core update this cycle
  assign quiet = !(int_op.valid || fp_op.valid || irq_accept || swi.valid);
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_answer;
    s_axi_rvalid && !s_axi_arready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_bank_follows: assert property (
    bank_sel == flags[cfs_pkg::POS_BANK]) else $error("bank select wrong");
  a_stack_follows: assert property (
    stack_sel == flags[cfs_pkg::POS_STK]) else $error("stack select wrong");
  a_ovf_tracks: assert property (int_op.valid |=>
    flags[cfs_pkg::POS_OVF] == $past(int_op.overflow))
    else $error("overflow flag wrong");
  a_fuf_tracks: assert property (fp_op.valid |=>
    flags[cfs_pkg::POS_FUF] == $past(fp_op.underflow | fp_op.subnormal))
    else $error("float underflow flag wrong");
  a_fof_tracks: assert property (fp_op.valid |=>
    flags[cfs_pkg::POS_FOF] == $past(fp_op.overflow | fp_op.subnormal))
    else $error("float overflow flag wrong");
  a_gate_level: assert property (
    irq_req.valid && irq_req.maskable |-> irq_accept == gate_ok)
    else $error("maskable accept wrong");
  a_accept_clears: assert property (irq_accept |=>
    !flags[cfs_pkg::POS_IEN] && !flags[cfs_pkg::POS_STK])
    else $error("accept left a flag set");
  a_swi_stack: assert property (swi.valid &&
    swi.number <= cfs_pkg::SWI_STK_MAX |=> !stack_sel)
    else $error("low number kept user stack");
  a_word_write: assert property (flag_wr.valid && quiet |=>
    flags == $past(flag_wr.data)) else $error("word write lost");
  a_read_answer: assert property (s_ar_take |=> s_r_answer)
    else $error("read answer late");
  a_bresp_hold: assert property (s_b_wait |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("response not held");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
endmodule

bind cfs_flags cfs_flags_checker u_chk (.aclk, .aresetn, .flag_wr, .int_op,
  .fp_op, .irq_req, .swi, .irq_accept, .flags, .bank_sel, .stack_sel,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);

//--- bench/tb_top.sv
// Randomised self-checking bench for the core flag register block
`timescale 1ns/1ps
module tb_top;
  logic aclk, aresetn; // Clock and reset
  cfs_pkg::cfs_flag_wr_t flag_wr; // Word write
  cfs_pkg::cfs_int_op_t  int_op; // Integer result
  cfs_pkg::cfs_fp_op_t   fp_op; // Float result
  cfs_pkg::cfs_irq_req_t irq_req; // Request
  cfs_pkg::cfs_swi_t     swi; // Software int
  logic irq_accept, bank_sel, stack_sel, irq; // Core outputs
  logic [10:0] flags; // Flag word
  logic [7:0]  s_axi_awaddr, s_axi_araddr; // Bus addresses
  logic [31:0] s_axi_wdata, s_axi_rdata; // Bus data
  logic [3:0]  s_axi_wstrb; // Byte enables
  logic [1:0]  s_axi_bresp, s_axi_rresp; // Responses
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready; // Read handshake
  integer seed; // Fixed random seed
  int fail_count, checks_done, cycles; // Bench counters
  logic [31:0] rnd, d; // Draws and read data
  logic [1:0]  r; // Response seen
  logic [10:0] f; // Flag word loaded
  logic        acc; // Expected accept
  logic [7:0]  offs [3] = '{8'h00, 8'h04, 8'h08}; // Mapped offsets
  logic [7:0]  nums [4] = '{8'h00, 8'h7f, 8'h80, 8'hff}; // Int numbers

  cfs_flags u_dut (.aclk, .aresetn, .flag_wr, .int_op, .fp_op, .irq_req,
    .swi, .irq_accept, .flags, .bank_sel, .stack_sel, .irq, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // ------------------------------------------------------------
  // Clock, watchdog and reporting
  // ------------------------------------------------------------
  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;
  // Ends a hung run; a clean one takes a few hundred cycles
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("Error at %0t: watchdog ran out", $time);
      close_out();
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      fail_count++;
      $display("Error at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  function automatic logic exp_acc(logic [10:0] fw, logic m, logic [2:0] l);
    return !m || (fw[2] && l > fw[10:8] && fw[10:8] != cfs_pkg::PRI_ALL_OFF);
  endfunction

  // ------------------------------------------------------------
  // Bus and core drivers
  // ------------------------------------------------------------
  // Ready is judged at the falling edge; answers wait a cycle
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_on, w_on;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, 4'hf};
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    {aw_on, w_on} = 2'b11;
    while (aw_on || w_on)
    begin
      @(negedge aclk);
      aw_on &= (s_axi_awready !== 1'b1);
      w_on &= (s_axi_wready !== 1'b1);
      @(posedge aclk);
      {s_axi_awvalid, s_axi_wvalid} <= {aw_on, w_on};
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  // Capture edge for core strobes, then drop them
  task automatic go;
    @(posedge aclk);
    {flag_wr, int_op, fp_op, irq_req, swi} <= '0;
    @(negedge aclk);
  endtask
  task automatic set_flags(input logic [10:0] v);
    @(posedge aclk);
    flag_wr <= '{1'b1, v};
    go();
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    seed = 32'h0e83bdc6;
    {aresetn, flag_wr, int_op, fp_op, irq_req, swi, s_axi_awaddr} = '0;
    {s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check(32'(flags), 32'h0);
    foreach (offs[i])
    begin
      axi_rd(offs[i]);
      check(d, 32'h0);
      check(32'(r), 32'(cfs_pkg::RESP_OKAY));
    end
    axi_rd(8'h0c);
    check(d, 32'h0);
    check(32'(r), 32'(cfs_pkg::RESP_SLVERR));
    axi_wr(8'h10, $random(seed));
    check(32'(r), 32'(cfs_pkg::RESP_SLVERR));
    // Word write, read back, select outputs
    repeat (4)
    begin
      rnd = $random(seed);
      axi_wr(cfs_pkg::OFF_FLAGS, rnd);
      axi_rd(cfs_pkg::OFF_FLAGS);
      check(d, rnd & 32'h7ff);
      check(32'(bank_sel), 32'(rnd[0]));
      check(32'(stack_sel), 32'(rnd[3]));
    end
    // Integer and float results together
    repeat (12)
    begin
      rnd = $random(seed);
      f = rnd[10:0] & 11'h73f;
      set_flags(f);
      @(posedge aclk);
      int_op <= '{1'b1, rnd[12]};
      fp_op <= '{1'b1, rnd[13], rnd[14], rnd[15] & rnd[16]};
      go();
      f[1] = rnd[12];
      f[4] = rnd[13] | (rnd[15] & rnd[16]);
      f[5] = rnd[14] | (rnd[15] & rnd[16]);
      check(32'(flags), 32'(f));
    end
    // Requests vs enable and level; level 7 first
    for (int i = 0; i < 24; i++)
    begin
      rnd = $random(seed);
      f = (rnd[10:0] & 11'h73f) | (i < 4 ? 11'h704 : 11'h000);
      set_flags(f);
      @(posedge aclk);
      irq_req <= '{1'b1, rnd[16] | rnd[17], rnd[20:18]};
      @(negedge aclk);
      acc = exp_acc(f, rnd[16] | rnd[17], rnd[20:18]);
      check(32'(irq_accept), 32'(acc));
      go();
      check(32'(flags), 32'(acc ? f & 11'h7f3 : f));
    end
    // Software numbers around the stack boundary
    foreach (nums[i])
    begin
      set_flags(11'h00c);
      @(posedge aclk);
      swi <= '{1'b1, nums[i]};
      go();
      check(32'(stack_sel), 32'(nums[i] > 8'h7f));
    end
    // Sticky events, mask and level interrupt
    axi_wr(cfs_pkg::OFF_MASK, 32'h0);
    axi_wr(cfs_pkg::OFF_STATUS, 32'h1f);
    axi_rd(cfs_pkg::OFF_STATUS);
    check(d, 32'h0);
    check(32'(irq), 32'h0);
    axi_wr(cfs_pkg::OFF_MASK, 32'(1) << cfs_pkg::EV_OVF);
    @(posedge aclk);
    int_op <= '{1'b1, 1'b1};
    go();
    @(negedge aclk);
    check(32'(irq), 32'h1);
    @(posedge aclk);
    fp_op <= '{1'b1, 1'b1, 1'b0, 1'b0};
    go();
    axi_rd(cfs_pkg::OFF_STATUS);
    rnd = (32'(1) << cfs_pkg::EV_OVF) | (32'(1) << cfs_pkg::EV_FUF);
    check(d, rnd);
    axi_wr(cfs_pkg::OFF_MASK, 32'(1) << cfs_pkg::EV_FUF);
    repeat (2) @(negedge aclk);
    check(32'(irq), 32'h1);
    axi_wr(cfs_pkg::OFF_STATUS, 32'(1) << cfs_pkg::EV_FUF);
    repeat (2) @(negedge aclk);
    check(32'(irq), 32'h0);
    close_out();
  end
endmodule
